// [spt_consts.svh]
// Constants for the sensor SPI slave port and its bus master.
`ifndef SPT_CONSTS_SVH
`define SPT_CONSTS_SVH
`define SPT_FRAME_BITS 5'h10
`define SPT_DATA_BITS 12
`define SPT_THR_DEFAULT 5'h15
`define SPT_CLK_NS 40
`define SPT_SCLK_HALF_NS 320
`define SPT_HALF_CYC ((`SPT_SCLK_HALF_NS + `SPT_CLK_NS - 1) / `SPT_CLK_NS)
`define SPT_SAMPLE_DLY 4'h4
`define SPT_MODE_SPI 1'b0
`define SPT_SYNC_RESET 6'h03
`define SPT_REPLY_FIRST 5'h02
`endif

// [spt_pkg.sv]
// Types for the two ends of the sensor SPI link: command codes for the port, frame states for the master.
package spt_pkg;
    typedef enum logic [1:0] {
        SPT_READ_TEMP = 2'h0,
        SPT_START_MEAS = 2'h1,
        SPT_SET_THR = 2'h2,
        SPT_UNUSED = 2'h3
    } spt_cmd_type;

    typedef enum logic [5:0] {
        SPT_IDLE = 6'h01,
        SPT_SETUP = 6'h02,
        SPT_HIGH = 6'h04,
        SPT_LOW = 6'h08,
        SPT_HOLD = 6'h10,
        SPT_DONE = 6'h20
    } spt_state_type;
endpackage

// [spt_link_if.sv]
// Four-wire link between the bus master and the sensor port.
`timescale 1ns/1ps
interface spt_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_out;
    logic miso_oe;
    logic miso;

    // Released data line floats high through the board pull-up.
    assign miso = miso_oe ? miso_out : 1'b1;

    modport dev (
        input sclk,
        input cs_n,
        input mosi,
        output miso_out,
        output miso_oe
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input miso
    );
endinterface

// [spt_sensor_port.sv]
// Sensor end of the link: SPI slave with sub-address match and commands.
`timescale 1ns/1ps
`include "spt_consts.svh"
module spt_sensor_port (
    input wire logic clk,
    input wire logic srst,
    spt_link_if.dev link,
    input wire logic mode_strap,
    input wire logic strap_addr_lo,
    input wire logic strap_addr_hi,
    input wire logic meas_busy,
    input wire logic meas_done,
    input wire logic [11:0] temp_value,
    output logic measure_start,
    output logic [4:0] threshold,
    output logic eol_enable,
    output logic i2c_selected
);
    localparam int NS = 6;

    ////////////////////////////////////////////////////////////////////
    // Three-stage pin synchroniser, its filtered view and one cycle of
    // history for finding edges.
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [NS-1:0] sync3_reg;
    logic [NS-1:0] filt_reg;
    logic [NS-1:0] prev_reg;
    logic [NS-1:0] filt_next;
    // Frame position and the bits taken from the master so far.
    logic [4:0] cnt_reg;
    logic [15:0] rx_reg;
    // Reply bits still to go out, captured once the address is known.
    logic [13:0] tx_reg;
    logic addressed_reg;
    // Data line and its enable; both drop together on deselect.
    logic miso_reg;
    logic oe_reg;
    // Command results towards the measurement core.
    logic start_reg;
    logic [4:0] thr_reg;
    logic have_result_reg;
    logic i2c_reg;

    // Matches a received command field against one command code; the
    // same compare serves every command that has an effect.
    function automatic logic spt_is_cmd(input logic [1:0] field,
                                        input spt_pkg::spt_cmd_type code);
        return field == code;
    endfunction

    // Pins pass three flops; a bit moves only when stages two and three
    // agree, which rejects single-cycle glitches on slow edges.
    assign filt_next = (~(sync2_reg ^ sync3_reg) & sync3_reg) |
                       ((sync2_reg ^ sync3_reg) & filt_reg);

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_reg <= `SPT_SYNC_RESET;
            sync2_reg <= `SPT_SYNC_RESET;
            sync3_reg <= `SPT_SYNC_RESET;
            filt_reg <= `SPT_SYNC_RESET;
            prev_reg <= `SPT_SYNC_RESET;
        end else begin
            sync1_reg <= {mode_strap, strap_addr_hi, strap_addr_lo,
                          link.mosi, link.cs_n, link.sclk};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= filt_next;
            prev_reg <= filt_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Filtered pins, named by what they carry.
    wire f_sclk = filt_reg[0];
    wire f_cs_n = filt_reg[1];
    wire f_mosi = filt_reg[2];
    wire f_a_lo = filt_reg[3];
    wire f_a_hi = filt_reg[4];
    wire f_mode = filt_reg[5];
    // I2C selection parks the SPI engine exactly like a high select.
    wire spi_off = f_cs_n | (f_mode != `SPT_MODE_SPI);
    // Edges of the filtered link clock: the master moves its data on
    // the rise and the port takes the bit on the fall.
    wire sclk_fall = prev_reg[0] & ~f_sclk;
    wire sclk_rise = ~prev_reg[0] & f_sclk;
    // Only sixteen bit times belong to a frame; further clocks while
    // still selected change nothing.
    wire frame_open = cnt_reg < `SPT_FRAME_BITS;
    wire take_bit = ~spi_off & sclk_fall & frame_open;
    // The reply begins at the third rise, when the address is known;
    // the first two bit times leave the line released.
    wire send_bit = ~spi_off & sclk_rise & addressed_reg &
                    (cnt_reg >= `SPT_REPLY_FIRST) & frame_open;
    wire [15:0] rx_full = {rx_reg[14:0], f_mosi};
    // First bit on the wire is the low sub-address bit.
    wire addr_hit = (rx_reg[0] == f_a_lo) & (f_mosi == f_a_hi);
    // The sixteenth fall closes the frame; an unaddressed port never
    // acts on what it heard.
    wire last_bit = take_bit & (cnt_reg == `SPT_FRAME_BITS - 5'h01);
    wire do_cmd = last_bit & addressed_reg;
    // Ready mirrors the core; a running measurement means that a new
    // start would be refused.
    wire ready = ~meas_busy;
    // A missing or half-made result is never shown to the master.
    wire [11:0] temp_shown = (meas_busy | ~have_result_reg) ?
                             12'h000 : temp_value;
    // Command decode on the completed frame.
    wire [1:0] cmd_bits = rx_full[13:12];
    wire is_start = do_cmd &
                    spt_is_cmd(cmd_bits, spt_pkg::SPT_START_MEAS);
    wire is_thr = do_cmd &
                  spt_is_cmd(cmd_bits, spt_pkg::SPT_SET_THR);

    // Bit counter and receive shift; extra clocks past sixteen are dropped.
    // A deselect clears the count at once, so a cut frame leaves
    // nothing behind for the next one.
    always_ff @(posedge clk) begin
        if (srst || spi_off) begin
            cnt_reg <= 5'h00;
            rx_reg <= 16'h0000;
        end else if (take_bit) begin
            cnt_reg <= cnt_reg + 5'h01;
            rx_reg <= rx_full;
        end
    end

    // Address decision after the second bit; reply is snapshotted then.
    // A mismatch keeps the data line released for the rest of the frame.
    always_ff @(posedge clk) begin
        if (srst || spi_off) begin
            addressed_reg <= 1'b0;
            tx_reg <= 14'h0000;
        end else if (take_bit && cnt_reg == 5'h01) begin
            addressed_reg <= addr_hit;
            tx_reg <= {ready, 1'b0, temp_shown};
        end else if (send_bit) begin
            tx_reg <= {tx_reg[12:0], 1'b0};
        end
    end

    // Output changes on the rise so the master can sample it in the low phase.
    // The enable stays up until deselect, so the line never flickers.
    always_ff @(posedge clk) begin
        if (srst || spi_off) begin
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (send_bit) begin
            miso_reg <= tx_reg[13];
            oe_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command effects; start is only honoured while ready.
    // A start that arrives while busy is dropped, not queued, and the
    // result flag is only ever set, so reset is its sole way back.
    always_ff @(posedge clk) begin
        if (srst) begin
            start_reg <= 1'b0;
            thr_reg <= `SPT_THR_DEFAULT;
            have_result_reg <= 1'b0;
            i2c_reg <= 1'b0;
        end else begin
            start_reg <= is_start & ready;
            if (is_thr) begin
                thr_reg <= rx_full[4:0];
            end
            if (meas_done) begin
                have_result_reg <= 1'b1;
            end
            i2c_reg <= f_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Every output comes straight from a register, so the data line
    // never carries a decode glitch.
    assign link.miso_out = miso_reg;
    assign link.miso_oe = oe_reg;
    assign measure_start = start_reg;
    assign threshold = thr_reg;
    // Top threshold bit zero switches battery sensing off.
    assign eol_enable = thr_reg[4];
    assign i2c_selected = i2c_reg;
endmodule

// [spt_bus_master.sv]
// Master end of the link: makes the clock and runs one 16-bit frame.
`timescale 1ns/1ps
`include "spt_consts.svh"
module spt_bus_master (
    input wire logic clk,
    input wire logic srst,
    spt_link_if.host link,
    input wire logic xfer_start,
    input wire logic [1:0] xfer_addr,
    input wire logic [1:0] xfer_cmd,
    input wire logic [11:0] xfer_data,
    output logic xfer_busy,
    output logic xfer_done,
    output logic [15:0] xfer_rx
);
    localparam logic [3:0] HALF_LAST = 4'(`SPT_HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    spt_pkg::spt_state_type st_reg, st_next;
    logic [3:0] ph_reg;
    logic [3:0] bit_reg;
    logic [15:0] tx_reg, rx_reg;
    logic sclk_reg, cs_n_reg, mosi_reg, done_reg;
    logic busy_reg;
    logic m1_reg, m2_reg, m3_reg, mf_reg;

    // Data line from the slave is a pin: three flops with agreement.
    always_ff @(posedge clk) begin
        if (srst) begin
            m1_reg <= 1'b1;
            m2_reg <= 1'b1;
            m3_reg <= 1'b1;
            mf_reg <= 1'b1;
        end else begin
            m1_reg <= link.miso;
            m2_reg <= m1_reg;
            m3_reg <= m2_reg;
            mf_reg <= (m2_reg == m3_reg) ? m3_reg : mf_reg;
        end
    end

    wire ph_end = ph_reg == HALF_LAST;
    // Sample late in the low phase to cover the slave's sync delay.
    wire sample = (st_reg == spt_pkg::SPT_LOW) & (ph_reg == `SPT_SAMPLE_DLY);
    wire last = bit_reg == 4'hf;

    // Frame sequencer: select, sixteen clocks, then hold before release.
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            spt_pkg::SPT_IDLE: begin
                if (xfer_start) begin
                    st_next = spt_pkg::SPT_SETUP;
                end
            end
            spt_pkg::SPT_SETUP: begin
                if (ph_end) begin
                    st_next = spt_pkg::SPT_HIGH;
                end
            end
            spt_pkg::SPT_HIGH: begin
                if (ph_end) begin
                    st_next = spt_pkg::SPT_LOW;
                end
            end
            spt_pkg::SPT_LOW: begin
                if (ph_end) begin
                    st_next = last ? spt_pkg::SPT_HOLD : spt_pkg::SPT_HIGH;
                end
            end
            spt_pkg::SPT_HOLD: begin
                if (ph_end) begin
                    st_next = spt_pkg::SPT_DONE;
                end
            end
            spt_pkg::SPT_DONE: st_next = spt_pkg::SPT_IDLE;
            default: st_next = spt_pkg::SPT_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst || st_reg != st_next) begin
            ph_reg <= 4'h0;
        end else begin
            ph_reg <= ph_reg + 4'h1;
        end
    end

    // Select goes low a half period before the first clock and rises only
    // a full period after the last fall.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= spt_pkg::SPT_IDLE;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            mosi_reg <= 1'b0;
            bit_reg <= 4'h0;
            tx_reg <= 16'h0000;
            rx_reg <= 16'h0000;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            busy_reg <= st_next != spt_pkg::SPT_IDLE;
            done_reg <= st_reg == spt_pkg::SPT_DONE;
            if (st_reg == spt_pkg::SPT_IDLE && xfer_start) begin
                cs_n_reg <= 1'b0;
                bit_reg <= 4'h0;
                tx_reg <= {xfer_addr[0], xfer_addr[1], xfer_cmd,
                           xfer_data};
            end
            if (st_next == spt_pkg::SPT_HIGH && st_reg != st_next) begin
                sclk_reg <= 1'b1;
                mosi_reg <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
            if (st_next != spt_pkg::SPT_HIGH &&
                st_reg == spt_pkg::SPT_HIGH) begin
                sclk_reg <= 1'b0;
            end
            if (sample) begin
                rx_reg <= {rx_reg[14:0], mf_reg};
            end
            if (st_reg == spt_pkg::SPT_LOW && ph_end && !last) begin
                bit_reg <= bit_reg + 4'h1;
            end
            if (st_reg == spt_pkg::SPT_HOLD && ph_end) begin
                cs_n_reg <= 1'b1;
            end
        end
    end

    assign link.sclk = sclk_reg;
    assign link.cs_n = cs_n_reg;
    assign link.mosi = mosi_reg;
    assign xfer_busy = busy_reg;
    assign xfer_done = done_reg;
    assign xfer_rx = rx_reg;
endmodule

// [spt_link_monitor.sv]
// Checker for the wire side of the sensor SPI link.
`timescale 1ns/1ps
module spt_link_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe
);
    logic [4:0] rise_cnt_reg;
    logic [4:0] fall_cnt_reg;
    logic sclk_d_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////
    // Counts raw link clock edges inside one select window.
    always_ff @(posedge clk) begin
        sclk_d_reg <= sclk;
        if (srst || cs_n) begin
            rise_cnt_reg <= 5'h00;
            fall_cnt_reg <= 5'h00;
        end else begin
            rise_cnt_reg <= rise_cnt_reg + {4'h0, sclk & ~sclk_d_reg};
            fall_cnt_reg <= fall_cnt_reg + {4'h0, ~sclk & sclk_d_reg};
        end
    end
    ////////////////////////////////////////////////////////////////////
    sclk_idle_low_a: assert property (cs_n |-> !sclk)
        else $error("link clock high while deselected");
    select_setup_a: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("link clock started too soon after select");
    high_width_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
        else $error("link clock high phase wrong length");
    mosi_steady_a: assert property (sclk && $past(sclk) |->
        $stable(mosi))
        else $error("mosi moved while clock high");
    frame_count_a: assert property ($rose(cs_n) |->
        rise_cnt_reg == 5'h10 && fall_cnt_reg == 5'h10)
        else $error("frame not sixteen clocks");
    quiet_till_addr_a: assert property (miso_oe && !cs_n |->
        fall_cnt_reg >= 5'h02)
        else $error("miso driven before address known");
    miso_settled_a: assert property (!cs_n && !sclk && $past(!sclk) &&
        miso_oe && $past(miso_oe) |-> $stable(miso_out))
        else $error("miso moved while clock low");
    release_after_a: assert property ($rose(cs_n) |-> ##[1:8] !miso_oe)
        else $error("miso not released after deselect");
endmodule

// [tb_sensor_spi_slave_port.sv]
// Testbench joining the bus master and the sensor port over one link.
`timescale 1ns/1ps
module tb_sensor_spi_slave_port;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic m_srst = 1'b0;
    logic xfer_start = 1'b0;
    logic [1:0] xfer_addr = 2'h0;
    logic [1:0] xfer_cmd = 2'h0;
    logic [11:0] xfer_data = 12'h000;
    logic xfer_busy;
    logic xfer_done;
    logic [15:0] xfer_rx;
    logic mode_strap = 1'b0;
    logic [1:0] strap = 2'h2;
    logic meas_busy = 1'b0;
    logic meas_done = 1'b0;
    logic [11:0] temp_value = 12'h000;
    logic measure_start;
    logic eol_enable;
    logic i2c_selected;
    logic [4:0] threshold;
    logic [4:0] exp_thr;
    int errors = 0;
    int total_checks = 0;
    int starts = 0;
    int cycles = 0;
    spt_link_if link ();
    // The master and the monitor alone can be reset mid-frame to cut a frame short.
    spt_bus_master spt_bus_master_inst (.clk(clk), .srst(srst | m_srst),
        .link(link), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
        .xfer_cmd(xfer_cmd), .xfer_data(xfer_data), .xfer_busy(xfer_busy),
        .xfer_done(xfer_done), .xfer_rx(xfer_rx));
    spt_sensor_port spt_sensor_port_inst (.clk(clk), .srst(srst),
        .link(link), .mode_strap(mode_strap), .strap_addr_lo(strap[0]),
        .strap_addr_hi(strap[1]), .meas_busy(meas_busy),
        .meas_done(meas_done), .temp_value(temp_value),
        .measure_start(measure_start), .threshold(threshold),
        .eol_enable(eol_enable), .i2c_selected(i2c_selected));
    spt_link_monitor spt_link_monitor_inst (.clk(clk), .srst(srst | m_srst),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
        .miso_out(link.miso_out), .miso_oe(link.miso_oe));
    ////////////////////////////////////////////////////////////////////
    // Clock of 40 ns period.
    initial begin
        forever #20 clk = ~clk;
    end
    // Counts start pulses and cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (measure_start === 1'b1) begin
            starts++;
        end
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Runs one frame; a nonzero cut resets the master after that many
    // cycles, which raises select in mid-frame.
    task frame(input logic [1:0] a, input logic [1:0] c,
        input logic [11:0] d, input int cut);
        int n;
        @(posedge clk);
        xfer_addr <= a;
        xfer_cmd <= c;
        xfer_data <= d;
        xfer_start <= 1'b1;
        @(posedge clk);
        xfer_start <= 1'b0;
        n = 0;
        #1;
        check("busy", {15'h0, xfer_busy}, 16'h0001);
        if (cut > 0) begin
            repeat (cut) @(posedge clk);
            m_srst <= 1'b1;
            repeat (3) @(posedge clk);
            m_srst <= 1'b0;
        end else begin
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (xfer_done !== 1'b1 && n < 400);
            check("done", {15'h0, n < 400}, 16'h0001);
            check("idle", {15'h0, xfer_busy}, 16'h0000);
        end
        repeat (4) @(posedge clk);
    endtask
    task summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence; replies read idle bits as ones from the pull-up.
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check("thr", {11'h0, threshold}, 16'h0015);
        check("eol", {15'h0, eol_enable}, 16'h0001);
        check("i2c", {15'h0, i2c_selected}, 16'h0000);
        frame(2'h2, spt_pkg::SPT_READ_TEMP, 12'h000, 0);
        check("rx none", xfer_rx, 16'he000);
        temp_value <= 12'h5a3;
        meas_done <= 1'b1;
        @(posedge clk);
        meas_done <= 1'b0;
        frame(2'h2, spt_pkg::SPT_READ_TEMP, 12'h000, 0);
        check("rx temp", xfer_rx, 16'he5a3);
        meas_busy <= 1'b1;
        frame(2'h2, spt_pkg::SPT_START_MEAS, 12'h000, 0);
        check("rx busy", xfer_rx, 16'hc000);
        check("starts", 16'(starts), 16'h0000);
        meas_busy <= 1'b0;
        frame(2'h2, spt_pkg::SPT_START_MEAS, 12'h000, 0);
        check("starts", 16'(starts), 16'h0001);
        frame(2'h2, spt_pkg::SPT_SET_THR, 12'h00a, 0);
        check("thr", {11'h0, threshold}, 16'h000a);
        check("eol", {15'h0, eol_enable}, 16'h0000);
        frame(2'h2, spt_pkg::SPT_UNUSED, 12'h011, 0);
        check("thr spare", {11'h0, threshold}, 16'h000a);
        check("starts spare", 16'(starts), 16'h0001);
        frame(2'h2, spt_pkg::SPT_SET_THR, 12'h011, 200);
        check("thr cut", {11'h0, threshold}, 16'h000a);
        exp_thr = 5'h0a;
        for (int a = 0; a < 4; a++) begin
            strap <= a[1:0];
            for (int b = 0; b < 4; b++) begin
                frame(b[1:0], spt_pkg::SPT_SET_THR,
                    {7'h00, 5'h10 | 5'(b)}, 0);
                if (a == b) begin
                    exp_thr = 5'h10 | 5'(b);
                end
                check("rx addr", xfer_rx,
                    (a == b) ? 16'he5a3 : 16'hffff);
                check("thr addr", {11'h0, threshold}, {11'h0, exp_thr});
            end
        end
        check("eol", {15'h0, eol_enable}, 16'h0001);
        mode_strap <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check("i2c", {15'h0, i2c_selected}, 16'h0001);
        frame(2'h3, spt_pkg::SPT_SET_THR, 12'h000, 0);
        check("rx i2c", xfer_rx, 16'hffff);
        check("thr i2c", {11'h0, threshold}, 16'h0013);
        summarize();
    end
endmodule
